/* File: exec_defines.svh */
// Timing, reset values and fixed addresses for the instruction execute unit.
// Assumes a system clock of 100 MHz and four system clocks per instruction cycle.
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

`define INSTR_CLKS      4'h4
`define PCL_ADDR        7'h06
`define FINAL_PAGE      2'h3
`define ACC_RESET       8'h00
`define PC_RESET        10'h000
`define TABLE_HIGH_BYTE_RESET      6'h00

`endif

/* File: exec_pkg.sv */
// Types shared by the instruction execute unit and its surroundings.
// Assumes instructions arrive already decoded from program memory.
package exec_pkg;

    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA, OP_AND, OP_OR, OP_XOR,
        OP_CPL, OP_INC, OP_DEC, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_MOV,
        OP_BCLR, OP_BSET, OP_CLR, OP_SET, OP_SWAP, OP_SZ, OP_SZA, OP_SZB,
        OP_SNZB, OP_SIZ, OP_SDZ, OP_JMP, OP_CALL, OP_RET, OP_RETL, OP_RETI,
        OP_TABC, OP_TABL, OP_WDT, OP_WDT1, OP_WDT2, OP_HALT
    } op_t;

    typedef struct packed {
        op_t         op;
        logic        to_mem;
        logic        use_imm;
        logic [6:0]  addr;
        logic [7:0]  imm;
        logic [2:0]  bit_idx;
        logic [9:0]  target;
    } instr_t;

    typedef struct packed {
        logic watchdog_timeout_flag;
        logic power_down_flag;
        logic signed_wrap_flag;
        logic zero_flag;
        logic nibble_carry_flag;
        logic carry_flag;
    } flags_t;

endpackage

/* File: mcu_instruction_execute.sv */
// Execute stage of an 8-bit accumulator machine: ALU, flags, PC, stack, table and watchdog.
// Assumes the caller presents mem_rdata and rom_word for the offered instruction in the
// same clock, and takes mem_we/mem_waddr/mem_wdata one clock after acceptance.
`timescale 1ns/100ps
`include "exec_defines.svh"

module mcu_instruction_execute
    import exec_pkg::*;
#(
    parameter int PC_W        = 10,
    parameter int STACK_DEPTH = 4
)(
    input  wire logic            clk,             // System clock, 100 MHz.
    input  wire logic            nrst,            // Asynchronous reset, active low.
    input  wire logic            en,              // Clock enable; low freezes all state.
    input  wire logic            instr_valid,     // A decoded instruction is offered.
    input  wire instr_t          instr,           // The offered instruction.
    input  wire logic [7:0]      mem_rdata,       // Data memory at instr.addr.
    input  wire logic [13:0]     rom_word,        // Program word at rom_addr.
    input  wire logic            wdt_single_clear,// High: one clear op; low: paired.
    input  wire logic            wdt_timeout_evt, // Watchdog expired this clock.
    output logic                 instr_ready,     // Unit takes an instruction now.
    output logic [PC_W-1:0]      rom_addr,        // Table fetch address.
    output logic [7:0]           acc,             // Accumulator.
    output flags_t               flags,           // Status flags.
    output logic [PC_W-1:0]      pc,              // Program counter.
    output logic [5:0]           table_high_byte, // High part of last table word.
    output logic                 mem_we,          // Data memory write strobe.
    output logic [6:0]           mem_waddr,       // Data memory write address.
    output logic [7:0]           mem_wdata,       // Data memory write data.
    output logic                 wdt_clear        // Watchdog counter clear pulse.
);
    localparam int SP_W = $clog2(STACK_DEPTH);

    logic [7:0]      acc_q, acc_d;
    flags_t          fl_q, fl_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [SP_W-1:0] sp_q, sp_d;
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [5:0]      table_high_byte_q, table_high_byte_d;
    logic            we_q, we_d;
    logic [6:0]      waddr_q, waddr_d;
    logic [7:0]      wdata_q, wdata_d;
    logic [3:0]      cnt_q, cnt_d;
    logic [1:0]      pre_q, pre_d;
    logic            wclr_q, wclr_d;
    logic            push;
    logic            accept;

    logic [7:0]  opnd, res, mask;
    logic [10:0] sum;
    logic        wr_res, skip, to_mem;
    logic [3:0]  ncyc;
    logic [4:0]  lo_adj;
    logic [4:0]  hi_adj;

    // Result bits {signed wrap, nibble carry, carry, sum}.
    function automatic logic [10:0] arith(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
    endfunction

    assign accept      = en && instr_valid && (cnt_q == 4'h0);
    assign instr_ready = (cnt_q == 4'h0);
    assign rom_addr    = (instr.op == OP_TABL) ? {`FINAL_PAGE, instr.imm}
                                               : {pc_q[PC_W-1:8], instr.imm};
    assign opnd        = instr.use_imm ? instr.imm : mem_rdata;
    assign mask        = 8'h01 << instr.bit_idx;

    always_comb
    begin
        acc_d   = acc_q;
        fl_d    = fl_q;
        pc_d    = pc_q;
        sp_d    = sp_q;
        table_high_byte_d  = table_high_byte_q;
        we_d    = 1'b0;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        cnt_d   = cnt_q;
        pre_d   = pre_q;
        wclr_d  = 1'b0;
        push    = 1'b0;
        res     = 8'h00;
        sum     = 11'h000;
        wr_res  = 1'b0;
        skip    = 1'b0;
        to_mem  = instr.to_mem;
        ncyc    = 4'h1;
        lo_adj  = 5'h00;
        hi_adj  = 5'h00;
        if (cnt_q != 4'h0)
        begin
            cnt_d = cnt_q - 4'h1;
        end
        else if (instr_valid)
        begin
            pc_d = pc_q + 1'b1;
            if (instr.op != OP_WDT1 && instr.op != OP_WDT2)
            begin
                pre_d = 2'b00;
            end
            unique case (instr.op)
                OP_ADD, OP_ADC, OP_SUB, OP_SBC:
                begin
                    if (instr.op == OP_ADD || instr.op == OP_ADC)
                        sum = arith(acc_q, opnd, (instr.op == OP_ADC) & fl_q.carry_flag);
                    else
                        sum = arith(acc_q, ~opnd, (instr.op == OP_SUB) | fl_q.carry_flag);
                    res    = sum[7:0];
                    wr_res = 1'b1;
                    fl_d.signed_wrap_flag  = sum[10];
                    fl_d.nibble_carry_flag = sum[9];
                    fl_d.carry_flag        = sum[8];
                    fl_d.zero_flag         = (sum[7:0] == 8'h00);
                end
                OP_DAA:
                begin
                    lo_adj = (acc_q[3:0] > 4'h9 || fl_q.nibble_carry_flag)
                           ? {1'b0, acc_q[3:0]} + 5'h06 : {1'b0, acc_q[3:0]};
                    hi_adj = {1'b0, acc_q[7:4]} + {4'h0, lo_adj[4]};
                    if (hi_adj > 5'h09 || fl_q.carry_flag)
                    begin
                        hi_adj          = hi_adj + 5'h06;
                        fl_d.carry_flag = 1'b1;
                    end
                    res    = {hi_adj[3:0], lo_adj[3:0]};
                    to_mem = 1'b1;
                    wr_res = 1'b1;
                end
                OP_AND, OP_OR, OP_XOR, OP_CPL:
                begin
                    unique case (instr.op)
                        OP_AND:  res = acc_q & opnd;
                        OP_OR:   res = acc_q | opnd;
                        OP_XOR:  res = acc_q ^ opnd;
                        default: res = ~mem_rdata;
                    endcase
                    wr_res         = 1'b1;
                    fl_d.zero_flag = (res == 8'h00);
                end
                OP_INC, OP_DEC:
                begin
                    res            = (instr.op == OP_INC) ? mem_rdata + 8'h01 : mem_rdata - 8'h01;
                    wr_res         = 1'b1;
                    fl_d.zero_flag = (res == 8'h00);
                end
                OP_RR:   begin res = {mem_rdata[0], mem_rdata[7:1]}; wr_res = 1'b1; end
                OP_RL:   begin res = {mem_rdata[6:0], mem_rdata[7]}; wr_res = 1'b1; end
                OP_RRC:
                begin
                    res             = {fl_q.carry_flag, mem_rdata[7:1]};
                    fl_d.carry_flag = mem_rdata[0];
                    wr_res          = 1'b1;
                end
                OP_RLC:
                begin
                    res             = {mem_rdata[6:0], fl_q.carry_flag};
                    fl_d.carry_flag = mem_rdata[7];
                    wr_res          = 1'b1;
                end
                OP_MOV:  begin res = instr.to_mem ? acc_q : opnd; wr_res = 1'b1; end
                OP_BCLR: begin res = mem_rdata & ~mask; to_mem = 1'b1; wr_res = 1'b1; end
                OP_BSET: begin res = mem_rdata | mask; to_mem = 1'b1; wr_res = 1'b1; end
                OP_CLR:  begin res = 8'h00; to_mem = 1'b1; wr_res = 1'b1; end
                OP_SET:  begin res = 8'hff; to_mem = 1'b1; wr_res = 1'b1; end
                OP_SWAP: begin res = {mem_rdata[3:0], mem_rdata[7:4]}; wr_res = 1'b1; end
                OP_SZ:   skip = (mem_rdata == 8'h00);
                OP_SZA:
                begin
                    res    = mem_rdata;
                    to_mem = 1'b0;
                    wr_res = 1'b1;
                    skip   = (mem_rdata == 8'h00);
                end
                OP_SZB:  skip = ((mem_rdata & mask) == 8'h00);
                OP_SNZB: skip = ((mem_rdata & mask) != 8'h00);
                OP_SIZ, OP_SDZ:
                begin
                    res    = (instr.op == OP_SIZ) ? mem_rdata + 8'h01 : mem_rdata - 8'h01;
                    wr_res = 1'b1;
                    skip   = (res == 8'h00);
                end
                OP_JMP:  begin pc_d = instr.target; ncyc = 4'h2; end
                OP_CALL:
                begin
                    push = 1'b1;
                    sp_d = sp_q + 1'b1;
                    pc_d = instr.target;
                    ncyc = 4'h2;
                end
                OP_RET, OP_RETL, OP_RETI:
                begin
                    sp_d = sp_q - 1'b1;
                    pc_d = stack_q[sp_q - 1'b1];
                    ncyc = 4'h2;
                    if (instr.op == OP_RETL)
                        acc_d = instr.imm;
                end
                OP_TABC, OP_TABL:
                begin
                    res    = rom_word[7:0];
                    table_high_byte_d = rom_word[13:8];
                    to_mem = 1'b1;
                    wr_res = 1'b1;
                    ncyc   = 4'h2;
                end
                OP_WDT:
                begin
                    if (wdt_single_clear)
                    begin
                        wclr_d                     = 1'b1;
                        fl_d.watchdog_timeout_flag = 1'b0;
                        fl_d.power_down_flag       = 1'b0;
                    end
                end
                OP_WDT1, OP_WDT2:
                begin
                    // Paired mode clears only when the other pre-clear came just before.
                    if (!wdt_single_clear && pre_q[instr.op == OP_WDT1])
                    begin
                        wclr_d                     = 1'b1;
                        pre_d                      = 2'b00;
                        fl_d.watchdog_timeout_flag = 1'b0;
                        fl_d.power_down_flag       = 1'b0;
                    end
                    else
                    begin
                        pre_d = (instr.op == OP_WDT1) ? 2'b01 : 2'b10;
                    end
                end
                OP_HALT:
                begin
                    wclr_d                     = 1'b1;
                    fl_d.watchdog_timeout_flag = 1'b0;
                    fl_d.power_down_flag       = 1'b1;
                end
                default: ;
            endcase
            if (wr_res && to_mem)
            begin
                we_d    = 1'b1;
                waddr_d = instr.addr;
                wdata_d = res;
                if (instr.addr == `PCL_ADDR)
                begin
                    pc_d = {pc_q[PC_W-1:8], res};
                    ncyc = ncyc + 4'h1;
                end
            end
            else if (wr_res)
            begin
                acc_d = res;
            end
            if (skip)
            begin
                pc_d = pc_q + 2'd2;
                ncyc = ncyc + 4'h1;
            end
            cnt_d = 4'(ncyc * `INSTR_CLKS) - 4'h1;
        end
        // A timeout in the same clock as a clear still sets the flag.
        if (wdt_timeout_evt)
            fl_d.watchdog_timeout_flag = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_q   <= `ACC_RESET;
            fl_q    <= '0;
            pc_q    <= `PC_RESET;
            sp_q    <= '0;
            table_high_byte_q  <= `TABLE_HIGH_BYTE_RESET;
            we_q    <= 1'b0;
            waddr_q <= 7'h00;
            wdata_q <= 8'h00;
            cnt_q   <= 4'h0;
            pre_q   <= 2'b00;
            wclr_q  <= 1'b0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_q[i] <= `PC_RESET;
        end
        else if (en)
        begin
            acc_q   <= acc_d;
            fl_q    <= fl_d;
            pc_q    <= pc_d;
            sp_q    <= sp_d;
            table_high_byte_q  <= table_high_byte_d;
            we_q    <= we_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            cnt_q   <= cnt_d;
            pre_q   <= pre_d;
            wclr_q  <= wclr_d;
            if (push)
                stack_q[sp_q] <= pc_q + 1'b1;
        end
    end

    assign acc             = acc_q;
    assign flags           = fl_q;
    assign pc              = pc_q;
    assign table_high_byte = table_high_byte_q;
    assign mem_we          = we_q;
    assign mem_waddr       = waddr_q;
    assign mem_wdata       = wdata_q;
    assign wdt_clear       = wclr_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !en);

    sequence s_wait2;
        !instr_ready [*7] ##1 instr_ready;
    endsequence

    property p_branch_two(op_t o);
        accept && instr.op == o |=> s_wait2;
    endproperty
    a_branch_two: assert property (p_branch_two(OP_JMP)) else $error("jump not two cycles");
    property p_call_push;
        accept && instr.op == OP_CALL |=> pc == $past(instr.target) && stack_q[sp_q - 1'b1] == $past(pc) + 1'b1;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");
    property p_ret_lit;
        accept && instr.op == OP_RETL |=> acc == $past(instr.imm) ##1 !instr_ready [*6];
    endproperty
    a_ret_lit: assert property (p_ret_lit) else $error("literal return wrong");
    property p_skip_extra;
        accept && instr.op == OP_SZ && mem_rdata == 8'h00 |=> s_wait2;
    endproperty
    a_skip_extra: assert property (p_skip_extra) else $error("skip not extended");
    property p_pcl_extra;
        accept && instr.op == OP_MOV && instr.to_mem && instr.addr == `PCL_ADDR |=> s_wait2;
    endproperty
    a_pcl_extra: assert property (p_pcl_extra) else $error("PC low write not extended");
    property p_logic_flags;
        accept && (instr.op == OP_AND || instr.op == OP_OR || instr.op == OP_XOR)
        |=> $stable({flags.carry_flag, flags.nibble_carry_flag, flags.signed_wrap_flag});
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic op changed flags");
    property p_move_flags;
        accept && instr.op == OP_MOV && !wdt_timeout_evt |=> $stable(flags);
    endproperty
    a_move_flags: assert property (p_move_flags) else $error("move changed flags");
    property p_halt_flags;
        accept && instr.op == OP_HALT && !wdt_timeout_evt
        |=> flags.power_down_flag && !flags.watchdog_timeout_flag && wdt_clear ##3 instr_ready;
    endproperty
    a_halt_flags: assert property (p_halt_flags) else $error("power-down wrong");
    property p_daa_only_c;
        accept && instr.op == OP_DAA
        |=> $stable({flags.zero_flag, flags.signed_wrap_flag, flags.nibble_carry_flag}) && mem_we;
    endproperty
    a_daa_only_c: assert property (p_daa_only_c) else $error("decimal fixup flags wrong");

endmodule

/* File: mcu_instruction_execute_tb_top.sv */
// Self-checking bench for the instruction execute unit, with seeded random ALU traffic.
// Assumes the unit accepts at a rising edge and drives instruction inputs at falling edges.
`timescale 1ns/100ps
`include "exec_defines.svh"
module mcu_instruction_execute_tb_top;
    import exec_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        en = 1'b1;
    logic        instr_valid = 1'b0;
    instr_t      instr = '0;
    logic [7:0]  mem_rdata = 8'h00;
    logic [13:0] rom_word = 14'h0000;
    logic        wdt_single_clear = 1'b1;
    logic        wdt_timeout_evt = 1'b0;
    logic        instr_ready;
    logic [9:0]  rom_addr;
    logic [7:0]  acc;
    flags_t      flags;
    logic [9:0]  pc;
    logic [5:0]  table_high_byte;
    logic        mem_we;
    logic [6:0]  mem_waddr;
    logic [7:0]  mem_wdata;
    logic        wdt_clear;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          n;
    logic [31:0] seed = 32'h8518;
    logic [7:0]  ea;
    flags_t      ef;
    logic [9:0]  ep;
    logic        we_s;
    logic        wc_s;
    logic [9:0]  ra_s;
    logic [11:0] r;
    logic [8:0]  d9;
    logic [7:0]  b8;
    op_t         ops [8] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_MOV};

    mcu_instruction_execute dut_u (
        .clk              (clk),
        .nrst             (nrst),
        .en               (en),
        .instr_valid      (instr_valid),
        .instr            (instr),
        .mem_rdata        (mem_rdata),
        .rom_word         (rom_word),
        .wdt_single_clear (wdt_single_clear),
        .wdt_timeout_evt  (wdt_timeout_evt),
        .instr_ready      (instr_ready),
        .rom_addr         (rom_addr),
        .acc              (acc),
        .flags            (flags),
        .pc               (pc),
        .table_high_byte  (table_high_byte),
        .mem_we           (mem_we),
        .mem_waddr        (mem_waddr),
        .mem_wdata        (mem_wdata),
        .wdt_clear        (wdt_clear)
    );

    always #5 clk = ~clk;

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Returns signed wrap, zero, nibble carry, carry and the sum.
    function automatic logic [11:0] addf(logic [7:0] a, logic [7:0] b, logic c);
        logic [8:0] s;
        logic [4:0] h;
        s = a + b + c;
        h = a[3:0] + b[3:0] + c;
        return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    function automatic logic [8:0] daa(logic [7:0] a, logic ac, logic c);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]};
        if (lo > 5'd9 || ac)
            lo = lo + 5'd6;
        hi = {1'b0, a[7:4]} + lo[4];
        if (hi > 5'd9 || c)
            return {1'b1, hi[3:0] + 4'h6, lo[3:0]};
        return {c, hi[3:0], lo[3:0]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cyc(input int got, input int exp);
        cmp_count++;
        if (got != exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: cycles %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // The mem_rdata operand is inverted after acceptance so a late sample cannot pass by luck; instr is left as offered.
    task automatic run(input op_t op, input logic tm, input logic ui, input logic [6:0] a,
                       input logic [7:0] im, input logic [2:0] b, input logic [9:0] t,
                       input logic [7:0] md);
        seed = lfsr(seed);
        rom_word = seed[13:0];
        instr = '{op, tm, ui, a, im, b, t};
        mem_rdata = md;
        instr_valid = 1'b1;
        #1 ra_s = rom_addr;
        @(posedge clk);
        @(negedge clk);
        instr_valid = 1'b0;
        mem_rdata = ~md;
        we_s = mem_we;
        wc_s = wdt_clear;
        n = 1;
        while (instr_ready !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic post(input int cyc);
        chk({acc, 2'b00, flags}, {ea, 2'b00, ef});
        chk({6'h00, pc}, {6'h00, ep});
        chk_cyc(n, cyc * 4);
    endtask

    task automatic memw(input logic [6:0] a, input logic [7:0] d);
        chk({we_s, mem_waddr, mem_wdata}, {1'b1, a, d});
    endtask

    task automatic alu(input op_t op, input logic ui, input logic [7:0] b);
        run(op, 1'b0, ui, 7'h10, ui ? b : ~b, 3'h0, 10'h000, ui ? ~b : b);
        r = {ef.signed_wrap_flag, ef.zero_flag, ef.nibble_carry_flag, ef.carry_flag, b};
        case (op)
            OP_ADD: r = addf(ea, b, 1'b0);
            OP_ADC: r = addf(ea, b, ef.carry_flag);
            OP_SUB: r = addf(ea, ~b, 1'b1);
            OP_SBC: r = addf(ea, ~b, ef.carry_flag);
            OP_AND: r[7:0] = ea & b;
            OP_OR: r[7:0] = ea | b;
            OP_XOR: r[7:0] = ea ^ b;
            default: r[7:0] = b;
        endcase
        if (op inside {OP_AND, OP_OR, OP_XOR})
            r[10] = (r[7:0] == 8'h00);
        {ef.signed_wrap_flag, ef.zero_flag, ef.nibble_carry_flag, ef.carry_flag, ea} = r;
        ep = ep + 10'h001;
        chk(we_s, 1'b0);
        post(1);
    endtask

    task automatic step(input op_t op, input logic [6:0] a, input logic [7:0] md,
                        input logic [7:0] wd, input int cyc);
        run(op, 1'b1, 1'b0, a, 8'h00, 3'h0, 10'h000, md);
        memw(a, wd);
        ep = ep + ((cyc == 2) ? 10'h002 : 10'h001);
        post(cyc);
    endtask

    task automatic wd(input op_t op, input logic wc, input logic to, input logic pd);
        run(op, 1'b0, 1'b0, 7'h10, 8'h00, 3'h0, 10'h000, 8'h00);
        chk(wc_s, wc);
        ef.watchdog_timeout_flag = to;
        ef.power_down_flag = pd;
        ep = ep + 10'h001;
        post(1);
    endtask

    initial
    begin
        #200000;
        fail_count++;
        end_sim();
    end

    initial
    begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        ea = 8'h00;
        ef = '0;
        ep = 10'h000;
        chk({acc, 2'b00, flags}, 16'h0000);
        chk({table_high_byte, pc}, 16'h0000);
        alu(OP_MOV, 1'b1, 8'h7f);
        alu(OP_ADD, 1'b1, 8'h01);
        alu(OP_MOV, 1'b1, 8'hff);
        alu(OP_ADD, 1'b0, 8'h01);
        alu(OP_ADC, 1'b0, 8'h7f);
        alu(OP_SUB, 1'b1, 8'h81);
        alu(OP_SBC, 1'b0, 8'h10);
        for (int i = 0; i < 40; i++)
        begin
            seed = lfsr(seed);
            alu(ops[seed[2:0]], seed[3], seed[15:8]);
        end
        r = addf(ea, 8'h34, ef.carry_flag);
        {ef.signed_wrap_flag, ef.zero_flag, ef.nibble_carry_flag, ef.carry_flag} = r[11:8];
        step(OP_ADC, 7'h21, 8'h34, r[7:0], 1);
        ef.zero_flag = 1'b1;
        step(OP_AND, 7'h21, 8'h00, 8'h00, 1);
        alu(OP_MOV, 1'b1, 8'h00);
        alu(OP_ADD, 1'b1, 8'h9a);
        d9 = daa(ea, ef.nibble_carry_flag, ef.carry_flag);
        ef.carry_flag = d9[8];
        step(OP_DAA, 7'h22, 8'h55, d9[7:0], 1);
        run(OP_INC, 1'b0, 1'b0, 7'h23, 8'h00, 3'h0, 10'h000, 8'hff);
        ea = 8'h00;
        ef.zero_flag = 1'b1;
        ep = ep + 10'h001;
        chk(we_s, 1'b0);
        post(1);
        ef.zero_flag = 1'b0;
        step(OP_DEC, 7'h23, 8'h05, 8'h04, 1);
        ef.carry_flag = 1'b1;
        step(OP_RRC, 7'h24, 8'h01, 8'h80, 1);
        ef.carry_flag = 1'b0;
        step(OP_RLC, 7'h24, 8'h40, 8'h81, 1);
        step(OP_RL, 7'h24, 8'h81, 8'h03, 1);
        step(OP_RR, 7'h24, 8'h01, 8'h80, 1);
        step(OP_CPL, 7'h2a, 8'h0f, 8'hf0, 1);
        step(OP_MOV, 7'h25, 8'h00, ea, 1);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            b8 = seed[7:0];
            run(i[0] ? OP_BSET : OP_BCLR, 1'b1, 1'b0, 7'h26, 8'h00, i[2:0], 10'h000, b8);
            memw(7'h26, i[0] ? (b8 | (8'h01 << i)) : (b8 & ~(8'h01 << i)));
            ep = ep + 10'h001;
            post(1);
        end
        run(OP_MOV, 1'b1, 1'b0, `PCL_ADDR, 8'h00, 3'h0, 10'h000, 8'h00);
        chk_cyc(n, 8);
        run(OP_JMP, 1'b0, 1'b0, 7'h10, 8'h00, 3'h0, 10'h155, 8'h00);
        ep = 10'h155;
        post(2);
        run(OP_CALL, 1'b0, 1'b0, 7'h10, 8'h00, 3'h0, 10'h2a0, 8'h00);
        ep = 10'h2a0;
        post(2);
        run(OP_CALL, 1'b0, 1'b0, 7'h10, 8'h00, 3'h0, 10'h3c0, 8'h00);
        ep = 10'h3c0;
        post(2);
        run(OP_RETL, 1'b0, 1'b0, 7'h10, 8'h5a, 3'h0, 10'h000, 8'h00);
        ea = 8'h5a;
        ep = 10'h2a1;
        post(2);
        run(OP_RETI, 1'b0, 1'b0, 7'h10, 8'h00, 3'h0, 10'h000, 8'h00);
        ep = 10'h156;
        post(2);
        run(OP_SZA, 1'b0, 1'b0, 7'h27, 8'h00, 3'h0, 10'h000, 8'h00);
        ea = 8'h00;
        ep = ep + 10'h002;
        post(2);
        run(OP_SZA, 1'b0, 1'b0, 7'h27, 8'h00, 3'h0, 10'h000, 8'h33);
        ea = 8'h33;
        ep = ep + 10'h001;
        post(1);
        run(OP_SZ, 1'b0, 1'b0, 7'h2b, 8'h00, 3'h0, 10'h000, 8'h00);
        ep = ep + 10'h002;
        post(2);
        run(OP_SZB, 1'b0, 1'b0, 7'h2b, 8'h00, 3'h5, 10'h000, 8'h20);
        ep = ep + 10'h001;
        post(1);
        run(OP_SNZB, 1'b0, 1'b0, 7'h2b, 8'h00, 3'h5, 10'h000, 8'h20);
        ep = ep + 10'h002;
        post(2);
        step(OP_SIZ, 7'h28, 8'hff, 8'h00, 2);
        step(OP_SDZ, 7'h28, 8'h02, 8'h01, 1);
        run(OP_SDZ, 1'b1, 1'b0, `PCL_ADDR, 8'h00, 3'h0, 10'h000, 8'h01);
        chk_cyc(n, 12);
        run(OP_RET, 1'b0, 1'b0, 7'h10, 8'h00, 3'h0, 10'h000, 8'h00);
        chk_cyc(n, 8);
        run(OP_JMP, 1'b0, 1'b0, 7'h10, 8'h00, 3'h0, 10'h1f0, 8'h00);
        ep = 10'h1f0;
        post(2);
        for (int i = 0; i < 2; i++)
        begin
            run(i ? OP_TABL : OP_TABC, 1'b1, 1'b0, 7'h29, 8'h44, 3'h0, 10'h000, 8'h00);
            chk(ra_s, {i ? 2'b11 : ep[9:8], 8'h44});
            chk(table_high_byte, rom_word[13:8]);
            memw(7'h29, rom_word[7:0]);
            ep = ep + 10'h001;
            post(2);
        end
        wdt_timeout_evt = 1'b1;
        @(negedge clk);
        wdt_timeout_evt = 1'b0;
        ef.watchdog_timeout_flag = 1'b1;
        wd(OP_WDT, 1'b1, 1'b0, 1'b0);
        wd(OP_HALT, 1'b1, 1'b0, 1'b1);
        wdt_single_clear = 1'b0;
        wd(OP_WDT, 1'b0, 1'b0, 1'b1);
        wd(OP_WDT1, 1'b0, 1'b0, 1'b1);
        wd(OP_NOP, 1'b0, 1'b0, 1'b1);
        wd(OP_WDT2, 1'b0, 1'b0, 1'b1);
        wd(OP_WDT2, 1'b0, 1'b0, 1'b1);
        wd(OP_WDT1, 1'b1, 1'b0, 1'b0);
        // With the clock enable low an offered jump must be ignored.
        en = 1'b0;
        run(OP_JMP, 1'b0, 1'b0, 7'h10, 8'h00, 3'h0, 10'h0aa, 8'h00);
        en = 1'b1;
        chk({6'h00, pc}, {6'h00, ep});
        chk_cyc(n, 1);
        nrst = 1'b0;
        @(negedge clk);
        chk({acc, 2'b00, flags}, 16'h0000);
        chk({table_high_byte, pc}, 16'h0000);
        nrst = 1'b1;
        end_sim();
    end
endmodule
